// File: rtl/pgd_pkg.sv
// constants, types and helper functions of the pattern generator and detector
package pgd_pkg;

    // register addresses
    localparam logic [7:0] PGD_ADDR_CTRL  = 8'hE0;
    localparam logic [7:0] PGD_ADDR_IRQ   = 8'hE1;
    localparam logic [7:0] PGD_ADDR_LEN   = 8'hE2;
    localparam logic [7:0] PGD_ADDR_TAP   = 8'hE3;
    localparam logic [7:0] PGD_ADDR_ERR   = 8'hE4;
    localparam logic [7:0] PGD_ADDR_SEED0 = 8'hE8;
    localparam logic [7:0] PGD_ADDR_SEED1 = 8'hE9;
    localparam logic [7:0] PGD_ADDR_SEED2 = 8'hEA;
    localparam logic [7:0] PGD_ADDR_SEED3 = 8'hEB;
    localparam logic [7:0] PGD_ADDR_DET0  = 8'hEC;
    localparam logic [7:0] PGD_ADDR_DET1  = 8'hED;
    localparam logic [7:0] PGD_ADDR_DET2  = 8'hEE;
    localparam logic [7:0] PGD_ADDR_DET3  = 8'hEF;

    // pattern_control fields
    localparam int PGD_CTRL_VIEW_HI = 7;
    localparam int PGD_CTRL_VIEW_LO = 6;
    localparam int PGD_CTRL_ZERO_SUPPRESS_ENABLE    = 5;
    localparam int PGD_CTRL_PS      = 4;
    localparam int PGD_CTRL_TX_INVERT    = 3;
    localparam int PGD_CTRL_RX_INVERT    = 2;
    localparam int PGD_CTRL_AUTO    = 1;
    localparam int PGD_CTRL_MAN     = 0;
    localparam logic [7:0] PGD_CTRL_RST = 8'h02;

    // pattern_irq_enable_status fields
    localparam int PGD_IRQ_EN_SYNC = 7;
    localparam int PGD_IRQ_EN_BERR = 6;
    localparam int PGD_IRQ_EN_XFER = 5;
    localparam int PGD_IRQ_SYNC_STATE   = 4;
    localparam int PGD_IRQ_SYNC_CHANGE_FLAG   = 3;
    localparam int PGD_IRQ_BEI     = 2;
    localparam int PGD_IRQ_TRANSFER_DONE_FLAG   = 1;
    localparam int PGD_IRQ_OVR     = 0;

    // error_insertion fields
    localparam int PGD_ERR_EVT = 3;
    localparam int PGD_FLD_W   = 5;
    localparam int PGD_EIR_W   = 3;

    localparam logic [1:0] PGD_VIEW_ERR  = 2'h2;
    localparam logic [1:0] PGD_VIEW_BITS = 2'h3;

    // synchronisation figures, in bits, except the window error limit, which counts errors
    localparam logic [5:0] PGD_SYNC_RUN = 6'h30;
    localparam logic [5:0] PGD_WIN_LEN  = 6'h30;
    localparam logic [4:0] PGD_WIN_LIM  = 5'h0A;
    localparam int         PGD_ZRUN     = 14;

    typedef enum logic [1:0] {PGD_DET_HUNT, PGD_DET_SYNC, PGD_DET_LOST} pgd_det_e;

    // bits between inserted errors for each rate code
    function automatic logic [23:0] pgd_rate_period(input logic [2:0] code);
        logic [23:0] p;
        p = 24'h00_0000;
        case (code)
            3'h1: p = 24'h00_000A;
            3'h2: p = 24'h00_0064;
            3'h3: p = 24'h00_03E8;
            3'h4: p = 24'h00_2710;
            3'h5: p = 24'h01_86A0;
            3'h6: p = 24'h0F_4240;
            3'h7: p = 24'h98_9680;
            default: p = 24'h00_0000;
        endcase
        return p;
    endfunction

    function automatic logic pgd_zero_run(input logic [31:0] sr);
        return (sr[PGD_ZRUN-1:0] == '0);
    endfunction

endpackage

// File: rtl/pgd_sat_cnt.sv
// saturating event counter with synchronous clear
`timescale 1ns/1ps
module pgd_sat_cnt #(
    parameter int W = 32
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rstn_i,
    input  wire logic         clr_i,
    input  wire logic         inc_i,
    output logic [W-1:0]      cnt_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } pgd_cnt_s;

    pgd_cnt_s q;
    pgd_cnt_s d;

    always_comb begin
        d = q;
        if (clr_i) begin
            // an event in the clearing cycle opens the new interval
            d.cnt = {{(W-1){1'b0}}, inc_i};
        end else if (inc_i && !(&q.cnt)) begin
            d.cnt = q.cnt + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cnt_o = q.cnt;
endmodule // pgd_sat_cnt

// File: rtl/pgd_pattern.sv
// pattern engine: feedback shift register or repeating seed, one bit per advance
`timescale 1ns/1ps
module pgd_pattern
    import pgd_pkg::*;
(
    input  wire logic                 clk_sys_i,
    input  wire logic                 rstn_i,
    input  wire logic                 adv_i,
    input  wire logic                 load_i,
    input  wire logic [31:0]          seed_i,
    input  wire logic                 ps_i,
    input  wire logic [PGD_FLD_W-1:0] len_i,
    input  wire logic [PGD_FLD_W-1:0] tap_i,
    input  wire logic                 zero_suppress_enable_i,
    input  wire logic                 feed_en_i,
    input  wire logic                 feed_bit_i,
    output logic                      bit_o
);
    typedef struct packed {
        logic [31:0]          sr;
        logic [PGD_FLD_W-1:0] idx;
    } pgd_pat_s;

    pgd_pat_s q;
    pgd_pat_s d;
    logic     fb;

    // length len+1 and tap tap+1 map onto indices len and tap
    assign fb    = q.sr[len_i] ^ q.sr[tap_i];
    assign bit_o = ps_i ? q.sr[q.idx] : (fb | (zero_suppress_enable_i && pgd_zero_run(q.sr)));

    always_comb begin
        d = q;
        if (load_i) begin
            d.sr  = seed_i;
            d.idx = 5'h1F;
        end else if (adv_i) begin
            if (ps_i) begin
                // first pass walks all 32 seed bits, later passes only len+1
                d.idx = (q.idx == '0) ? len_i : q.idx - 5'h01;
            end else begin
                d.sr = {q.sr[30:0], feed_en_i ? feed_bit_i : fb};
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule // pgd_pattern

// File: rtl/pgd_top.sv
// pattern generator and detector with its register file
// Behaviour
// - view select routes error count, bit count or received pattern to readout bytes
// - with zero suppression on, generator forces a one after fourteen zeros in pseudo-random mode only
// - detector expects the same forced ones when zero suppression is on
// - pattern select picks repetitive pattern at 1, pseudo-random at 0
// - tx invert inverts every generated bit before it leaves
// - rx invert inverts received bits before the detector sees them
// - auto resync restarts the hunt after 10 errors in a 48-bit window
// - a 0 to 1 write of manual resync starts one resynchronisation
// - sync state rises after 48 clean bits, falls at 10 errors per window
// - sync change flag sets on gain or loss, clears on status read
// - bit error flag sets on any error detected while in sync, clears on status read
// - bit errors are flagged only while synchronised
// - readout or global update write latches holders and sets transfer flag
// - overrun sets when a new transfer lands on an unread one
// - enables at bits 7, 6, 5 gate sync, error and transfer interrupts
// - pattern length equals length field plus one
// - feedback tap equals tap field plus one
// - each 0 to 1 write of the event bit inserts exactly one error
// - error rate code 0 inserts none, codes 1 to 7 one per ten to ten million
// - writing the seed top byte loads the full seed into the generator
// - repetitive pattern sends seed bit 31 down to 0, then length-1 down to 0
// - holders keep saturating counts of last interval, counting only in sync
// - received-pattern holder keeps last 32 bits, newest in bit zero
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module pgd_top
    import pgd_pkg::*;
#(
    parameter int CNT_W = 32
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic [7:0]      rdata_o,
    input  wire logic       gupd_i,
    input  wire logic       tx_adv_i,
    output logic            tx_bit_o,
    input  wire logic       rx_valid_i,
    input  wire logic       rx_bit_i,
    output logic            sync_state_o,
    output logic            irq_o
);
    typedef struct packed {
        logic [7:0]           ctrl;
        logic [2:0]           irq_en;
        logic [PGD_FLD_W-1:0] len;
        logic [PGD_FLD_W-1:0] tap;
        logic                 evt;
        logic [PGD_EIR_W-1:0] eir;
        logic [31:0]          seed;
        logic                 sync_chg;
        logic                 bit_err;
        logic                 xfer;
        logic                 overrun_flag;
        logic [31:0]          hold_pat;
        logic [CNT_W-1:0]     hold_err;
        logic [CNT_W-1:0]     hold_bits;
        logic [31:0]          rx_hist;
        pgd_det_e             det_st;
        logic [5:0]           run;
        logic [5:0]           win;
        logic [4:0]           win_err;
        logic                 ev_pend;
        logic [23:0]          rate_cnt;
        logic                 tx_bit;
        logic [7:0]           rdata;
    } pgd_state_s;

    pgd_state_s       q;
    pgd_state_s       d;

    logic             wr_ctrl;
    logic             wr_err;
    logic             seed_load;
    logic             upd;
    logic             st_rd;
    logic             man_rise;
    logic             evt_rise;
    logic             gen_bit;
    logic             det_bit;
    logic             rxb;
    logic             expect_bit;
    logic             bit_bad;
    logic             rate_hit;
    logic             inject;
    logic             in_sync;
    logic             cnt_en;
    logic [4:0]       err_sum;
    logic             lose;
    logic [23:0]      rate_nxt;
    logic [CNT_W-1:0] err_cnt;
    logic [CNT_W-1:0] bit_cnt;
    logic [CNT_W-1:0] view_word;
    logic [7:0]       status;

    // bus decode; everything runs on the system clock so no crossing is needed
    assign wr_ctrl   = wr_i && (addr_i == PGD_ADDR_CTRL);
    assign wr_err    = wr_i && (addr_i == PGD_ADDR_ERR);
    assign seed_load = wr_i && (addr_i == PGD_ADDR_SEED3);
    assign upd       = gupd_i || (wr_i && (addr_i >= PGD_ADDR_DET0) && (addr_i <= PGD_ADDR_DET3));
    assign st_rd     = rd_i && (addr_i == PGD_ADDR_IRQ);
    assign man_rise  = wr_ctrl && wdata_i[PGD_CTRL_MAN] && !q.ctrl[PGD_CTRL_MAN];
    assign evt_rise  = wr_err && wdata_i[PGD_ERR_EVT] && !q.evt;

    // transmit side
    pgd_pattern u_gen (
        .clk_sys_i  (clk_sys_i),
        .rstn_i     (rstn_i),
        .adv_i      (tx_adv_i),
        .load_i     (seed_load),
        .seed_i     ({wdata_i, q.seed[23:0]}),
        .ps_i       (q.ctrl[PGD_CTRL_PS]),
        .len_i      (q.len),
        .tap_i      (q.tap),
        .zero_suppress_enable_i     (q.ctrl[PGD_CTRL_ZERO_SUPPRESS_ENABLE]),
        .feed_en_i  (1'b0),
        .feed_bit_i (1'b0),
        .bit_o      (gen_bit)
    );

    assign rate_nxt = q.rate_cnt + 24'h00_0001;
    assign rate_hit = tx_adv_i && (q.eir != '0) && (rate_nxt >= pgd_rate_period(q.eir));
    assign inject   = q.ev_pend || rate_hit;

    // receive side; while hunting the detector register is loaded from the line
    assign rxb = rx_bit_i ^ q.ctrl[PGD_CTRL_RX_INVERT];

    pgd_pattern u_det (
        .clk_sys_i  (clk_sys_i),
        .rstn_i     (rstn_i),
        .adv_i      (rx_valid_i),
        .load_i     (1'b0),
        .seed_i     (32'h0000_0000),
        .ps_i       (1'b0),
        .len_i      (q.len),
        .tap_i      (q.tap),
        .zero_suppress_enable_i     (q.ctrl[PGD_CTRL_ZERO_SUPPRESS_ENABLE]),
        .feed_en_i  (q.det_st == PGD_DET_HUNT),
        .feed_bit_i (rxb),
        .bit_o      (det_bit)
    );

    // a repeating pattern predicts itself from the bit one length back
    assign expect_bit = q.ctrl[PGD_CTRL_PS] ? q.rx_hist[q.len] : det_bit;
    assign bit_bad    = rx_valid_i && (rxb != expect_bit);
    assign in_sync    = (q.det_st == PGD_DET_SYNC);
    assign cnt_en     = rx_valid_i && in_sync;
    assign err_sum    = q.win_err + {4'h0, bit_bad};
    assign lose       = cnt_en && (err_sum >= PGD_WIN_LIM);

    pgd_sat_cnt #(
        .W (CNT_W)
    ) u_err_cnt (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .clr_i     (upd),
        .inc_i     (cnt_en && bit_bad),
        .cnt_o     (err_cnt)
    );

    pgd_sat_cnt #(
        .W (CNT_W)
    ) u_bit_cnt (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .clr_i     (upd),
        .inc_i     (cnt_en),
        .cnt_o     (bit_cnt)
    );

    always_comb begin
        unique case (q.ctrl[PGD_CTRL_VIEW_HI:PGD_CTRL_VIEW_LO])
            PGD_VIEW_ERR:  view_word = q.hold_err;
            PGD_VIEW_BITS: view_word = q.hold_bits;
            default:       view_word = q.hold_pat;
        endcase
    end

    assign status = {q.irq_en, in_sync, q.sync_chg, q.bit_err, q.xfer, q.overrun_flag};

    always_comb begin
        d = q;
        // register writes
        if (wr_ctrl) begin
            d.ctrl = wdata_i;
        end
        if (wr_i && (addr_i == PGD_ADDR_IRQ)) begin
            d.irq_en = wdata_i[PGD_IRQ_EN_SYNC:PGD_IRQ_EN_XFER];
        end
        if (wr_i && (addr_i == PGD_ADDR_LEN)) begin
            d.len = wdata_i[PGD_FLD_W-1:0];
        end
        if (wr_i && (addr_i == PGD_ADDR_TAP)) begin
            d.tap = wdata_i[PGD_FLD_W-1:0];
        end
        if (wr_err) begin
            d.evt = wdata_i[PGD_ERR_EVT];
            d.eir = wdata_i[PGD_EIR_W-1:0];
        end
        if (wr_i && (addr_i == PGD_ADDR_SEED0)) begin
            d.seed[7:0] = wdata_i;
        end
        if (wr_i && (addr_i == PGD_ADDR_SEED1)) begin
            d.seed[15:8] = wdata_i;
        end
        if (wr_i && (addr_i == PGD_ADDR_SEED2)) begin
            d.seed[23:16] = wdata_i;
        end
        if (seed_load) begin
            d.seed[31:24] = wdata_i;
        end

        // transmit: one bit per strobe, errors and inversion on the way out
        if (tx_adv_i) begin
            d.tx_bit  = gen_bit ^ inject ^ q.ctrl[PGD_CTRL_TX_INVERT];
            d.ev_pend = 1'b0;
        end
        if (evt_rise) begin
            d.ev_pend = 1'b1;
        end
        if (q.eir == '0) begin
            d.rate_cnt = '0;
        end else if (tx_adv_i) begin
            d.rate_cnt = rate_hit ? 24'h00_0000 : rate_nxt;
        end

        // receive: history, then synchronisation state
        if (rx_valid_i) begin
            d.rx_hist = {q.rx_hist[30:0], rxb};
        end
        if (rx_valid_i) begin
            unique case (q.det_st)
                PGD_DET_SYNC: begin
                    if (lose) begin
                        // without auto resync the detector free-runs until a manual restart
                        d.det_st  = q.ctrl[PGD_CTRL_AUTO] ? PGD_DET_HUNT : PGD_DET_LOST;
                        d.run     = '0;
                        d.win     = '0;
                        d.win_err = '0;
                    end else if (q.win == PGD_WIN_LEN - 6'h01) begin
                        d.win     = '0;
                        d.win_err = '0;
                    end else begin
                        d.win     = q.win + 6'h01;
                        d.win_err = err_sum;
                    end
                end
                PGD_DET_HUNT, PGD_DET_LOST: begin
                    if (bit_bad) begin
                        d.run = '0;
                    end else if (q.run == PGD_SYNC_RUN - 6'h01) begin
                        d.det_st  = PGD_DET_SYNC;
                        d.run     = '0;
                        d.win     = '0;
                        d.win_err = '0;
                    end else begin
                        d.run = q.run + 6'h01;
                    end
                end
            endcase
        end
        if (man_rise) begin
            d.det_st  = PGD_DET_HUNT;
            d.run     = '0;
            d.win     = '0;
            d.win_err = '0;
        end

        // accumulation transfer
        if (upd) begin
            d.hold_pat  = q.rx_hist;
            d.hold_err  = err_cnt;
            d.hold_bits = bit_cnt;
        end

        // sticky flags: a status read clears, a same-cycle event wins, except overrun, which a same-cycle read suppresses
        d.sync_chg = ((d.det_st == PGD_DET_SYNC) != in_sync) || (q.sync_chg && !st_rd);
        d.bit_err  = (cnt_en && bit_bad) || (q.bit_err && !st_rd);
        d.xfer     = upd || (q.xfer && !st_rd);
        d.overrun_flag      = (upd && q.xfer && !st_rd) || (q.overrun_flag && !st_rd);

        // read data for the next cycle only
        d.rdata = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                PGD_ADDR_CTRL:  d.rdata = q.ctrl;
                PGD_ADDR_IRQ:   d.rdata = status;
                PGD_ADDR_LEN:   d.rdata = {3'h0, q.len};
                PGD_ADDR_TAP:   d.rdata = {3'h0, q.tap};
                PGD_ADDR_ERR:   d.rdata = {4'h0, q.evt, q.eir};
                PGD_ADDR_SEED0: d.rdata = q.seed[7:0];
                PGD_ADDR_SEED1: d.rdata = q.seed[15:8];
                PGD_ADDR_SEED2: d.rdata = q.seed[23:16];
                PGD_ADDR_SEED3: d.rdata = q.seed[31:24];
                PGD_ADDR_DET0:  d.rdata = view_word[7:0];
                PGD_ADDR_DET1:  d.rdata = view_word[15:8];
                PGD_ADDR_DET2:  d.rdata = view_word[23:16];
                PGD_ADDR_DET3:  d.rdata = view_word[31:24];
                default:        d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q        <= '0;
            q.ctrl   <= PGD_CTRL_RST;
            q.det_st <= PGD_DET_HUNT;
        end else begin
            q <= d;
        end
    end

    assign rdata_o      = q.rdata;
    assign tx_bit_o     = q.tx_bit;
    assign sync_state_o = in_sync;
    assign irq_o        = |(q.irq_en & {q.sync_chg, q.bit_err, q.xfer});

    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    sequence s_manual_rise;
        wr_ctrl && wdata_i[PGD_CTRL_MAN] && !q.ctrl[PGD_CTRL_MAN];
    endsequence

    sequence s_transfer;
        upd ##1 q.xfer;
    endsequence

    AST_VIEW_ERR: assert property (rd_i && addr_i == PGD_ADDR_DET0 &&
        q.ctrl[PGD_CTRL_VIEW_HI:PGD_CTRL_VIEW_LO] == PGD_VIEW_ERR && !upd |=> rdata_o == q.hold_err[7:0])
        else $error("readout byte does not show error count");

    AST_TX_INVERT: assert property (tx_adv_i && !inject && q.ctrl[PGD_CTRL_TX_INVERT] && !wr_ctrl
        |=> tx_bit_o != $past(gen_bit))
        else $error("transmitted bit not inverted");

    AST_SYNC_GAIN: assert property ($rose(in_sync) |-> $past(q.run) == PGD_SYNC_RUN - 6'h01)
        else $error("sync gained without 48 clean bits");

    AST_SYNC_LOSS: assert property ($fell(in_sync) && !$past(man_rise)
        |-> $past(err_sum) >= PGD_WIN_LIM)
        else $error("sync lost without 10 errors in window");

    AST_AUTO_OFF: assert property (lose && !q.ctrl[PGD_CTRL_AUTO] && !man_rise
        |=> q.det_st == PGD_DET_LOST ##1 (q.det_st != PGD_DET_HUNT || $past(man_rise)))
        else $error("resync started with auto resync off");

    AST_MANUAL: assert property (s_manual_rise |=> q.det_st == PGD_DET_HUNT && q.run == '0)
        else $error("manual resync did not restart hunt");

    AST_XFER_SET: assert property (s_transfer |-> q.hold_bits == $past(bit_cnt))
        else $error("transfer flag without holding update");

    AST_OVERRUN: assert property (upd && q.xfer && !st_rd |=> q.overrun_flag [*2] or (q.overrun_flag ##1 $past(st_rd)))
        else $error("overrun not flagged");

    AST_STATUS_CLEAR: assert property (st_rd && !cnt_en |=> !q.bit_err)
        else $error("status read did not clear bit error flag");

    AST_ERR_IN_SYNC: assert property ($rose(q.bit_err) |-> $past(in_sync))
        else $error("bit error flagged while out of sync");

    AST_NO_COUNT: assert property (!in_sync && !upd |=> $stable(err_cnt) && $stable(bit_cnt))
        else $error("counting while out of sync");

    AST_IRQ: assert property (q.xfer && q.irq_en[0] |-> irq_o ##1 (irq_o || $past(st_rd) || !q.irq_en[0]))
        else $error("interrupt missing for enabled transfer flag");
endmodule // pgd_top

// File: test/pgd_link_model.sv
// loopback model of the transceiver bit streams
`timescale 1ns/1ps
module pgd_link_model (
    input  wire logic clk_sys_i,
    input  wire logic rstn_i,
    input  wire logic tx_adv_i,
    input  wire logic tx_bit_i,
    output logic      rx_valid_o,
    output logic      rx_bit_o
);
    // bit appears the cycle after the strobe, so valid lags one cycle
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) rx_valid_o <= 1'b0;
        else rx_valid_o <= tx_adv_i;
    end
    // outside a bit the line shows junk, never the last value
    assign rx_bit_o = rx_valid_o ? tx_bit_i : ~tx_bit_i;
endmodule // pgd_link_model

// File: test/test_pgd_top.sv
// self-checking bench of the pattern generator and detector
`timescale 1ns/1ps
module test_pgd_top import pgd_pkg::*; ();
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        gupd = 1'b0;
    logic        adv = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  rdata;
    logic        tx_bit, rx_valid, rx_bit, sync, irq;
    logic [31:0] seed = 32'hA5C3_0F96;
    logic [31:0] w;
    int          fails = 0;
    int          total_checks = 0;
    int          pos = 0;
    int          diffs;
    int          len = 8;
    logic        inv = 1'b0;
    logic        lo;
    always #5 clk = ~clk;
    pgd_top dut (.clk_sys_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .gupd_i(gupd), .tx_adv_i(adv), .tx_bit_o(tx_bit), .rx_valid_i(rx_valid),
        .rx_bit_i(rx_bit), .sync_state_o(sync), .irq_o(irq));
    pgd_link_model link (.clk_sys_i(clk), .rstn_i(rstn), .tx_adv_i(adv), .tx_bit_i(tx_bit),
        .rx_valid_o(rx_valid), .rx_bit_o(rx_bit));
    task automatic summarize;
        if (fails == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk8(rdata, exp);
    endtask
    // repeating seed: 31 down to 0 once, then len-1 down to 0
    function automatic logic ebit(input int p);
        return (p < 32) ? seed[31-p] : seed[len-1-(p-32)%len];
    endfunction
    task automatic bits(input int n, input logic cmp);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            adv <= 1'b1;
            @(posedge clk);
            adv <= 1'b0;
            #1;
            if (cmp && tx_bit !== (ebit(pos) ^ inv)) diffs++;
            if (sync !== 1'b1) lo = 1'b1;
            pos++;
        end
    endtask
    task automatic seed_all(input logic [7:0] b);
        for (int i = 0; i < 4; i++) wr_reg(PGD_ADDR_SEED0 + 8'(i), b);
    endtask
    initial begin
        #300us;
        fails++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(PGD_ADDR_CTRL, 8'h02);
        rd_reg(PGD_ADDR_IRQ, 8'h00);
        rd_reg(8'hE5, 8'h00);
        wr_reg(PGD_ADDR_CTRL, 8'h12);
        wr_reg(PGD_ADDR_LEN, 8'hE7);
        rd_reg(PGD_ADDR_LEN, 8'h07);
        wr_reg(PGD_ADDR_TAP, 8'hFF);
        rd_reg(PGD_ADDR_TAP, 8'h1F);
        for (int i = 0; i < 4; i++) wr_reg(PGD_ADDR_SEED0 + 8'(i), seed[8*i +: 8]);
        diffs = 0;
        bits(96, 1'b1);
        chk8(8'(diffs), 8'h00);
        chk1(sync, 1'b1);
        rd_reg(PGD_ADDR_IRQ, 8'h18);
        rd_reg(PGD_ADDR_IRQ, 8'h10);
        wr_reg(PGD_ADDR_DET0, 8'h00);
        bits(20, 1'b1);
        repeat (3) @(posedge clk);
        for (int k = 0; k < 32; k++) w[k] = ebit(pos - 1 - k);
        wr_reg(PGD_ADDR_DET1, 8'h00);
        for (int i = 0; i < 4; i++) rd_reg(PGD_ADDR_DET0 + 8'(i), w[8*i +: 8]);
        wr_reg(PGD_ADDR_CTRL, 8'hD2);
        rd_reg(PGD_ADDR_DET0, 8'h14);
        rd_reg(PGD_ADDR_DET1, 8'h00);
        wr_reg(PGD_ADDR_CTRL, 8'h92);
        rd_reg(PGD_ADDR_DET0, 8'h00);
        rd_reg(PGD_ADDR_IRQ, 8'h13);
        wr_reg(PGD_ADDR_IRQ, 8'h20);
        #1 chk1(irq, 1'b0);
        @(posedge clk);
        gupd <= 1'b1;
        @(posedge clk);
        gupd <= 1'b0;
        @(posedge clk);
        #1 chk1(irq, 1'b1);
        rd_reg(PGD_ADDR_IRQ, 8'h32);
        chk1(irq, 1'b0);
        wr_reg(PGD_ADDR_ERR, 8'h08);
        diffs = 0;
        bits(16, 1'b1);
        chk8(8'(diffs), 8'h01);
        rd_reg(PGD_ADDR_IRQ, 8'h34);
        wr_reg(PGD_ADDR_ERR, 8'h08);
        diffs = 0;
        bits(16, 1'b1);
        chk8(8'(diffs), 8'h00);
        wr_reg(PGD_ADDR_ERR, 8'h01);
        diffs = 0;
        bits(40, 1'b1);
        chk8(8'(diffs), 8'h04);
        wr_reg(PGD_ADDR_ERR, 8'h00);
        wr_reg(PGD_ADDR_CTRL, 8'h1A);
        inv = 1'b1;
        diffs = 0;
        bits(16, 1'b1);
        chk8(8'(diffs), 8'h00);
        wr_reg(PGD_ADDR_CTRL, 8'h02);
        wr_reg(PGD_ADDR_LEN, 8'h06);
        wr_reg(PGD_ADDR_TAP, 8'h05);
        seed_all(8'hFF);
        bits(120, 1'b0);
        chk1(sync, 1'b1);
        // inverted pseudo-random line never agrees with itself
        wr_reg(PGD_ADDR_CTRL, 8'h04);
        lo = 1'b0;
        bits(60, 1'b0);
        chk1(lo, 1'b1);
        // auto resync off: detector keeps its phase and locks again on a clean line
        wr_reg(PGD_ADDR_CTRL, 8'h00);
        bits(60, 1'b0);
        chk1(sync, 1'b1);
        wr_reg(PGD_ADDR_CTRL, 8'h01);
        #1 chk1(sync, 1'b0);
        bits(60, 1'b0);
        chk1(sync, 1'b1);
        wr_reg(PGD_ADDR_CTRL, 8'h02);
        seed_all(8'h00);
        bits(1, 1'b0);
        chk1(tx_bit, 1'b0);
        wr_reg(PGD_ADDR_CTRL, 8'h22);
        wr_reg(PGD_ADDR_SEED3, 8'h00);
        bits(1, 1'b0);
        chk1(tx_bit, 1'b1);
        summarize();
    end
endmodule // test_pgd_top
